// File: verilog/rti_pkg.sv
/*
 * Shared constants and types for the root-table and context-cache invalidation block.
 * Assumes a 32-bit APB master on the register side and one clock for the whole block.
 */
`default_nettype none
package rti_pkg;
    // Register byte offsets, one aligned 32-bit word each.
    localparam logic [7:0] RTI_OFF_ROOT_LO = 8'h20;
    localparam logic [7:0] RTI_OFF_ROOT_HI = 8'h24;
    localparam logic [7:0] RTI_OFF_CCMD_LO = 8'h28;
    localparam logic [7:0] RTI_OFF_CCMD_HI = 8'h2C;
    localparam logic [7:0] RTI_OFF_CTRL    = 8'h30;
    localparam logic [7:0] RTI_OFF_STAT    = 8'h34;
    localparam logic [7:0] RTI_OFF_ACT_LO  = 8'h38;
    localparam logic [7:0] RTI_OFF_ACT_HI  = 8'h3C;
    // Field positions inside the 32-bit words.
    localparam int RTI_RTT_BIT      = 11;
    localparam int RTI_BASE_LSB     = 12;
    localparam int RTI_ICC_BIT      = 31;
    localparam int RTI_REQ_GRAN_LSB = 29;
    localparam int RTI_ACT_GRAN_LSB = 27;
    localparam int RTI_SID_LSB      = 16;
    localparam int RTI_CTRL_SET_ROOT_POINTER_COMMAND    = 0;
    localparam int RTI_CTRL_TE      = 1;
    localparam int RTI_CTRL_ECS     = 2;
    localparam int RTI_CTRL_WRITE_BUFFER_FLUSH_REQUIRED    = 3;
    localparam int RTI_STAT_RPS     = 0;
    localparam int RTI_STAT_TES     = 1;
    localparam int RTI_STAT_FLUSH   = 2;
    localparam int RTI_STAT_INV     = 3;
    // Granularity encodings and reset values.
    localparam logic [1:0] RTI_GRAN_RSVD   = 2'h0;
    localparam logic [1:0] RTI_GRAN_GLOBAL = 2'h1;
    localparam logic [1:0] RTI_GRAN_DOMAIN = 2'h2;
    localparam logic [1:0] RTI_GRAN_DEVICE = 2'h3;
    localparam logic [1:0] RTI_GRAN_RESET  = 2'h0;
    localparam logic [31:0] RTI_WORD_ZERO  = 32'h0000_0000;

    // APB request and response bundles; field names follow the bus.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } rti_apb_req_t;
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rti_apb_rsp_t;

    // One invalidation command as handed to the context cache.
    typedef struct packed {
        logic [1:0]  gran;
        logic [15:0] domain_identifier;
        logic [15:0] source_identifier;
        logic [1:0]  fm;
    } rti_inv_cmd_t;

    typedef enum logic [1:0] {ENG_IDLE, ENG_FLUSH, ENG_INVAL} rti_eng_state_t;

    // Merge a written word into an old one under the APB byte strobes.
    function automatic logic [31:0] rti_merge(input logic [31:0] old, input logic [31:0] wr,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = wr[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Accept a reported granularity only if it is not finer than requested.
    function automatic logic [1:0] rti_legal_gran(input logic [1:0] req, input logic [1:0] rep);
        logic [1:0] res;
        res = RTI_GRAN_GLOBAL;
        if (rep == RTI_GRAN_DOMAIN && req != RTI_GRAN_GLOBAL) begin
            res = rep;
        end else if (rep == RTI_GRAN_DEVICE && req == RTI_GRAN_DEVICE) begin
            res = rep;
        end
        return res;
    endfunction
endpackage
`default_nettype wire

// File: verilog/rti_flush_unit.sv
/*
 * Write-buffer flush handshake used ahead of a context-cache invalidation.
 * Assumes the flush agent answers wbFlushReq with a one-cycle wbFlushDone.
 */
`timescale 1ns/1ps
`default_nettype none
module rti_flush_unit
    import rti_pkg::*;
(
    input  wire logic clk,          // Block clock.
    input  wire logic rst,          // Asynchronous reset, active high.
    input  wire logic start,        // One-cycle request to flush.
    input  wire logic wbFlushDone,  // One-cycle completion from the flush agent.
    output logic      wbFlushReq,   // Held high while the flush runs.
    output logic      done          // One-cycle completion back to the engine.
);
    typedef struct packed {
        logic req;
        logic done;
    } rti_flush_regs_t;

    rti_flush_regs_t r_q;  // Registered state.
    rti_flush_regs_t r_d;  // Next state.

    ////////////////////////////////////////////////////////////////////////////
    // Request is raised by start and dropped on the agent's done.
    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        if (r_q.req && wbFlushDone) begin
            r_d.req = 1'b0;
            r_d.done = 1'b1;
        end else if (start) begin
            r_d.req = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign wbFlushReq = r_q.req;
    assign done       = r_q.done;
endmodule
`default_nettype wire

// File: verilog/rti_inval_engine.sv
/*
 * Sequencer for one context-cache invalidation: optional flush, then the cache request.
 * Assumes the cache answers cacheReq with a one-cycle cacheDone and its applied granularity.
 */
`timescale 1ns/1ps
`default_nettype none
module rti_inval_engine
    import rti_pkg::*;
(
    input  wire logic         clk,         // Block clock.
    input  wire logic         rst,         // Asynchronous reset, active high.
    input  wire logic         start,       // One-cycle start of an invalidation.
    input  wire rti_inv_cmd_t cmd,         // Command fields, valid with start.
    input  wire logic         write_buffer_flush_required,        // Write-buffer flush required.
    input  wire logic         flushDone,   // One-cycle flush completion.
    input  wire logic         cacheDone,   // One-cycle cache completion.
    input  wire logic [1:0]   cacheGran,   // Granularity the cache applied.
    output logic              flushStart,  // One-cycle flush request.
    output logic              cacheReq,    // Held high until cacheDone.
    output rti_inv_cmd_t      cacheCmd,    // Command presented to the cache.
    output logic              done,        // One-cycle completion.
    output logic [1:0]        actGran      // Applied granularity, valid with done.
);
    typedef struct packed {
        rti_eng_state_t state;
        rti_inv_cmd_t   cmd;
        logic           flushStart;
        logic           cacheReq;
        logic           done;
        logic [1:0]     actGran;
    } rti_eng_regs_t;

    rti_eng_regs_t r_q;  // Registered state.
    rti_eng_regs_t r_d;  // Next state.

    ////////////////////////////////////////////////////////////////////////////
    // Flush first when required, then hold the cache request until it finishes.
    always_comb begin
        r_d = r_q;
        r_d.flushStart = 1'b0;
        r_d.done = 1'b0;
        case (r_q.state)
            ENG_IDLE: begin
                if (start) begin
                    r_d.cmd = cmd;
                    // A reserved request is served as the coarsest one.
                    if (cmd.gran == RTI_GRAN_RSVD) begin
                        r_d.cmd.gran = RTI_GRAN_GLOBAL;
                    end
                    if (write_buffer_flush_required) begin
                        r_d.flushStart = 1'b1;
                        r_d.state = ENG_FLUSH;
                    end else begin
                        r_d.cacheReq = 1'b1;
                        r_d.state = ENG_INVAL;
                    end
                end
            end
            ENG_FLUSH: begin
                if (flushDone) begin
                    r_d.cacheReq = 1'b1;
                    r_d.state = ENG_INVAL;
                end
            end
            ENG_INVAL: begin
                if (cacheDone) begin
                    r_d.cacheReq = 1'b0;
                    r_d.done = 1'b1;
                    r_d.actGran = rti_legal_gran(r_q.cmd.gran, cacheGran);
                    r_d.state = ENG_IDLE;
                end
            end
            default: begin
                r_d.state = ENG_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign flushStart = r_q.flushStart;
    assign cacheReq   = r_q.cacheReq;
    assign cacheCmd   = r_q.cmd;
    assign done       = r_q.done;
    assign actGran    = r_q.actGran;
endmodule
`default_nettype wire

// File: verilog/rti_root_ctx_top.sv
/*
 * Register bank for the root-table base and the context-cache command, with its sequencer.
 * Assumes an APB master with byte strobes, one clock, and a context cache and flush agent
 * that answer their requests with one-cycle done pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module rti_root_ctx_top
    import rti_pkg::*;
#(
    parameter int HOST_ADDRESS_WIDTH       = 48,  // Supported host address width.
    parameter int DID_WIDTH = 16   // Supported domain-id width.
) (
    input  wire logic         clk,              // Block clock, 40 MHz.
    input  wire logic         rst,              // Asynchronous reset, active high.
    input  wire rti_apb_req_t apbReq,           // APB request from software.
    output rti_apb_rsp_t      apbRsp,           // APB response to software.
    output logic [63:0]       rootBaseActive,   // Root base in use by the walker.
    output logic              rootTypeActive,   // Table format in use.
    output logic              translationEnable,// Translation enable status.
    output logic              ccInvReq,         // Context-cache invalidation request.
    output rti_inv_cmd_t      ccInvCmd,         // Command fields for the cache.
    input  wire logic         ccInvDone,        // One-cycle cache completion.
    input  wire logic [1:0]   ccDoneGran,       // Granularity the cache applied.
    output logic              wbFlushReq,       // Write-buffer flush request.
    input  wire logic         wbFlushDone       // One-cycle flush completion.
);
    // Masks for the implemented address and domain bits; upper bits stay zero.
    localparam logic [63:0] HAW_MASK = ~(64'hFFFF_FFFF_FFFF_FFFF << HOST_ADDRESS_WIDTH);
    localparam logic [15:0] DID_MASK = ~(16'hFFFF << DID_WIDTH);

    // Whole register state of this module.
    typedef struct packed {
        logic [51:0] rootStage;    // Base bits 63:12 as last written.
        logic        rttStage;     // Table type as last written.
        logic [51:0] rootActive;   // Base bits latched by the set command.
        logic        rttActive;    // Table type latched by the set command.
        logic        rootPtrStat;  // Set once a base has been latched.
        logic        transEn;      // Translation enable.
        logic        extended_capability_support_flag;          // Extended capability support flag.
        logic        write_buffer_flush_required;         // Write-buffer flush required flag.
        logic        invalidate_bit;          // Invalidate bit.
        logic [1:0]  reqGran;      // Requested granularity.
        logic [1:0]  actGran;      // Actual granularity.
        logic [15:0] source_identifier;          // Source identifier.
        logic [15:0] domain_identifier;          // Domain identifier.
        logic [1:0]  fm;           // Function mask.
        logic        startPulse;   // One-cycle start towards the engine.
        logic [31:0] prdata;       // Read data prepared in the setup phase.
        logic        pslverr;      // Error flag prepared in the setup phase.
    } rti_regs_t;

    rti_regs_t    r_q;          // Registered state.
    rti_regs_t    r_d;          // Next state.
    logic         setupPhase;   // APB setup cycle.
    logic         writeAccess;  // APB write completing this edge.
    logic         addrMapped;   // Address hits a register.
    logic [31:0]  wordNew;      // Merged write word.
    logic [31:0]  readWord;     // Word selected for reading.
    logic         engDone;      // Engine completion pulse.
    logic [1:0]   engActGran;   // Engine applied granularity.
    logic         flushStart;   // Engine asks for a flush.
    logic         flushDone;    // Flush completed.
    logic         engBusy;      // Engine request in flight.
    rti_inv_cmd_t startCmd;     // Command handed to the engine.

    ////////////////////////////////////////////////////////////////////////////
    // Address decode: only aligned words of the known offsets are mapped.
    always_comb begin
        case (apbReq.paddr)
            RTI_OFF_ROOT_LO, RTI_OFF_ROOT_HI, RTI_OFF_CCMD_LO, RTI_OFF_CCMD_HI,
            RTI_OFF_CTRL, RTI_OFF_STAT, RTI_OFF_ACT_LO, RTI_OFF_ACT_HI: begin
                addrMapped = 1'b1;
            end
            default: begin
                addrMapped = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; reserved and write-only fields return zero.
    always_comb begin
        readWord = RTI_WORD_ZERO;
        case (apbReq.paddr)
            RTI_OFF_ROOT_LO: begin
                // The staged value is returned, latched or not.
                readWord[31:RTI_BASE_LSB] = r_q.rootStage[19:0];
                readWord[RTI_RTT_BIT] = r_q.rttStage & r_q.extended_capability_support_flag;
            end
            RTI_OFF_ROOT_HI: begin
                readWord = r_q.rootStage[51:20];
            end
            RTI_OFF_CCMD_LO: begin
                // Source identifier is write-only and reads as zero.
                readWord[15:0] = r_q.domain_identifier;
            end
            RTI_OFF_CCMD_HI: begin
                readWord[RTI_ICC_BIT] = r_q.invalidate_bit;
                readWord[RTI_REQ_GRAN_LSB +: 2] = r_q.reqGran;
                readWord[RTI_ACT_GRAN_LSB +: 2] = r_q.actGran;
                // Function mask is write-only; bits 26:0 read zero.
            end
            RTI_OFF_CTRL: begin
                // The set command is self-clearing and reads zero.
                readWord[RTI_CTRL_TE] = r_q.transEn;
                readWord[RTI_CTRL_ECS] = r_q.extended_capability_support_flag;
                readWord[RTI_CTRL_WRITE_BUFFER_FLUSH_REQUIRED] = r_q.write_buffer_flush_required;
            end
            RTI_OFF_STAT: begin
                readWord[RTI_STAT_RPS] = r_q.rootPtrStat;
                readWord[RTI_STAT_TES] = r_q.transEn;
                readWord[RTI_STAT_FLUSH] = wbFlushReq;
                readWord[RTI_STAT_INV] = engBusy;
            end
            RTI_OFF_ACT_LO: begin
                readWord[31:RTI_BASE_LSB] = r_q.rootActive[19:0];
                readWord[RTI_RTT_BIT] = r_q.rttActive;
            end
            RTI_OFF_ACT_HI: begin
                readWord = r_q.rootActive[51:20];
            end
            default: begin
                readWord = RTI_WORD_ZERO;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus writes, read capture and engine completion.
    always_comb begin
        r_d = r_q;
        r_d.startPulse = 1'b0;
        setupPhase = apbReq.psel && !apbReq.penable;
        writeAccess = apbReq.psel && apbReq.penable && apbReq.pwrite;
        wordNew = RTI_WORD_ZERO;

        // Completion clears the busy bit and posts the applied granularity together.
        if (engDone) begin
            r_d.invalidate_bit = 1'b0;
            r_d.actGran = engActGran;
        end

        // Read data and error are taken from flops during the setup phase.
        if (setupPhase) begin
            r_d.prdata = apbReq.pwrite ? RTI_WORD_ZERO : readWord;
            r_d.pslverr = !addrMapped;
        end

        if (writeAccess && addrMapped) begin
            case (apbReq.paddr)
                RTI_OFF_ROOT_LO: begin
                    wordNew = rti_merge({r_q.rootStage[19:0], r_q.rttStage, 11'h000},
                                        apbReq.pwdata, apbReq.pstrb);
                    // Bits 11:0 of the base are implied zero by the 4 KB alignment.
                    r_d.rootStage[19:0] = wordNew[31:RTI_BASE_LSB] & HAW_MASK[31:12];
                    // Without extended support the type bit is not writable.
                    if (r_q.extended_capability_support_flag) begin
                        r_d.rttStage = wordNew[RTI_RTT_BIT];
                    end
                end
                RTI_OFF_ROOT_HI: begin
                    wordNew = rti_merge(r_q.rootStage[51:20], apbReq.pwdata, apbReq.pstrb);
                    r_d.rootStage[51:20] = wordNew & HAW_MASK[63:32];
                end
                RTI_OFF_CCMD_LO: begin
                    // Writes while an invalidation runs are dropped to protect the engine.
                    if (!r_q.invalidate_bit) begin
                        wordNew = rti_merge({r_q.source_identifier, r_q.domain_identifier}, apbReq.pwdata, apbReq.pstrb);
                        r_d.source_identifier = wordNew[31:RTI_SID_LSB];
                        r_d.domain_identifier = wordNew[15:0] & DID_MASK;
                    end
                end
                RTI_OFF_CCMD_HI: begin
                    if (!r_q.invalidate_bit) begin
                        wordNew = rti_merge({1'b0, r_q.reqGran, 27'h0000000, r_q.fm},
                                            apbReq.pwdata, apbReq.pstrb);
                        r_d.reqGran = wordNew[RTI_REQ_GRAN_LSB +: 2];
                        r_d.fm = wordNew[1:0];
                        // Only a top-byte write with the bit set starts work.
                        if (apbReq.pstrb[3] && apbReq.pwdata[RTI_ICC_BIT]) begin
                            r_d.invalidate_bit = 1'b1;
                            r_d.startPulse = 1'b1;
                        end
                        // Otherwise the fields are merely stored.
                    end
                end
                RTI_OFF_CTRL: begin
                    if (apbReq.pstrb[0]) begin
                        // The base is taken into use only by this command.
                        if (apbReq.pwdata[RTI_CTRL_SET_ROOT_POINTER_COMMAND]) begin
                            r_d.rootActive = r_q.rootStage;
                            r_d.rttActive = r_q.rttStage & r_q.extended_capability_support_flag;
                            r_d.rootPtrStat = 1'b1;
                        end
                        r_d.transEn = apbReq.pwdata[RTI_CTRL_TE];
                        r_d.extended_capability_support_flag = apbReq.pwdata[RTI_CTRL_ECS];
                        r_d.write_buffer_flush_required = apbReq.pwdata[RTI_CTRL_WRITE_BUFFER_FLUSH_REQUIRED];
                    end
                end
                default: begin
                    // Status and active-copy words are read-only.
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; everything resets to zero, including the invalidate bit.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Engine and flush handshake. The command is taken from the stored fields the
    // cycle after the starting write, when they are already settled.
    always_comb begin
        startCmd.gran = r_q.reqGran;
        startCmd.domain_identifier = r_q.domain_identifier;
        startCmd.source_identifier = r_q.source_identifier;
        startCmd.fm = r_q.fm;
    end

    rti_inval_engine u_engine (
        .clk        (clk),
        .rst        (rst),
        .start      (r_q.startPulse),
        .cmd        (startCmd),
        .write_buffer_flush_required       (r_q.write_buffer_flush_required),
        .flushDone  (flushDone),
        .cacheDone  (ccInvDone),
        .cacheGran  (ccDoneGran),
        .flushStart (flushStart),
        .cacheReq   (ccInvReq),
        .cacheCmd   (ccInvCmd),
        .done       (engDone),
        .actGran    (engActGran)
    );

    rti_flush_unit u_flush (
        .clk         (clk),
        .rst         (rst),
        .start       (flushStart),
        .wbFlushDone (wbFlushDone),
        .wbFlushReq  (wbFlushReq),
        .done        (flushDone)
    );

    // Busy covers the gap between the start pulse and the engine's request.
    assign engBusy = r_q.invalidate_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Outputs. The slave never inserts wait states, so pready is tied high.
    assign apbRsp.pready     = 1'b1;
    assign apbRsp.pslverr    = r_q.pslverr;
    assign apbRsp.prdata     = r_q.prdata;
    assign rootBaseActive    = {r_q.rootActive, 12'h000};
    assign rootTypeActive    = r_q.rttActive;
    assign translationEnable = r_q.transEn;
endmodule
`default_nettype wire

// File: verif/rti_root_ctx_asserts.sv
/* Port checker for the register block top; assumes the designer's stated handshake latencies. */
`timescale 1ns/1ps
`default_nettype none
module rti_root_ctx_asserts
    import rti_pkg::*;
#(parameter int HOST_ADDRESS_WIDTH = 48) (
    input wire logic         clk,
    input wire logic         rst,
    input wire rti_apb_req_t apbReq,
    input wire logic [63:0]  rootBaseActive,
    input wire logic         ccInvReq,
    input wire rti_inv_cmd_t ccInvCmd,
    input wire logic         ccInvDone,
    input wire logic         wbFlushReq,
    input wire logic         wbFlushDone
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Completed writes; a start is only counted while the engine is idle.
    wire wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
    wire goInv = wrAcc && apbReq.paddr == 8'h2C && apbReq.pstrb[3] && apbReq.pwdata[31] && !ccInvReq && !wbFlushReq;
    wire goRoot = wrAcc && apbReq.paddr == 8'h30 && apbReq.pwdata[0];
    ////////////////////////
    inv_start_a: assert property (goInv |-> ##[2:3] (ccInvReq || wbFlushReq)) else $error("no start");
    flush_first_a: assert property (wbFlushReq && wbFlushDone |-> ##[1:3] ccInvReq) else $error("no request");
    req_hold_a: assert property (ccInvReq && !ccInvDone |=> ccInvReq) else $error("request dropped");
    req_clear_a: assert property (ccInvReq && ccInvDone |=> !ccInvReq) else $error("request stuck");
    cmd_stable_a: assert property (ccInvReq && $past(ccInvReq) |-> $stable(ccInvCmd)) else $error("cmd moved");
    gran_legal_a: assert property ($rose(ccInvReq) |-> ccInvCmd.gran != RTI_GRAN_RSVD) else $error("bad gran");
    base_bits_a: assert property ((rootBaseActive >> HOST_ADDRESS_WIDTH) == 64'h0 && rootBaseActive[11:0] == 12'h0) else $error("base");
    base_latch_a: assert property (!$stable(rootBaseActive) |-> $past(goRoot)) else $error("base moved");
endmodule
bind rti_root_ctx_top rti_root_ctx_asserts #(.HOST_ADDRESS_WIDTH(HOST_ADDRESS_WIDTH)) rti_root_ctx_asserts_i (.*);
`default_nettype wire

// File: verif/tb_top.sv
/* Self-checking bench: plays software over APB, the context cache and the flush agent. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rti_pkg::*;
;
    logic         clk = 1'b0, rst = 1'b1, ccDone = 1'b0, wbDone = 1'b0, ccReq, wbReq;
    logic [1:0]   gRep = 2'h1;
    logic [32:0]  expQ[$];
    int           miscompares = 0, samples_checked = 0;
    rti_apb_req_t req = '0;
    rti_apb_rsp_t rsp;
    rti_root_ctx_top rti_root_ctx_top_i (.clk(clk), .rst(rst), .apbReq(req), .apbRsp(rsp), .rootBaseActive(),
        .rootTypeActive(), .translationEnable(), .ccInvReq(ccReq), .ccInvCmd(), .ccInvDone(ccDone),
        .ccDoneGran(gRep), .wbFlushReq(wbReq), .wbFlushDone(wbDone));
    always #12.5 clk = ~clk;
    ////////////////////////
    task automatic cmp(input string n, logic [32:0] e, logic [32:0] g);
        samples_checked++;
        miscompares += int'(g !== e);
        if (g !== e) $display("wrong value %s expected %h seen %h", n, e, g);
    endtask
    // Agents answer after random waits; reads are checked when the access completes.
    always @(posedge clk) begin
        ccDone <= ccReq && !ccDone && $urandom % 3 == 0;
        wbDone <= wbReq && !wbDone && $urandom % 2 == 0;
        if (req.psel && req.penable && !req.pwrite) cmp("read", expQ.pop_front(), {rsp.pslverr, rsp.prdata});
    end
    // One APB transfer, held until pready is seen high.
    task automatic apb(input logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
        @(posedge clk) req <= '{1'b1, 1'b0, w, a, d, 4'hF};
        if (!w) expQ.push_back(e);
        @(posedge clk) req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        req <= '0;
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0]  ac;
        void'($urandom(32'h37428E94));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h44, 32'h0, 33'h1_0000_0000);
        d = $urandom;
        apb(1'b1, 8'h20, d | 32'h800, 33'h0);
        apb(1'b1, 8'h24, d, 33'h0);
        apb(1'b0, 8'h20, 32'h0, {1'b0, d & 32'hFFFF_F000});
        apb(1'b0, 8'h24, 32'h0, {17'h0, d[15:0]});
        apb(1'b1, 8'h30, 32'h5, 33'h0);
        apb(1'b0, 8'h38, 32'h0, {1'b0, d & 32'hFFFF_F000});
        apb(1'b1, 8'h28, d, 33'h0);
        // Every requested code, with and without the flush step.
        for (int i = 0; i < 8; i++) begin
            ac = $urandom;
            gRep <= ac;
            ac = (ac == 2'h2 && i[1]) ? 2'h2 : (ac == 2'h3 && i[1:0] == 2'h3) ? 2'h3 : 2'h1;
            apb(1'b1, 8'h30, {28'h0, i[2], 3'h4}, 33'h0);
            apb(1'b1, 8'h2C, {1'b1, i[1:0], 29'h3}, 33'h0);
            // Command word left alone until done; the bit clears two edges after the pulse.
            for (int n = 0; n < 99 && !(ccReq && ccDone); n++) @(negedge clk);
            repeat (2) @(posedge clk);
            apb(1'b0, 8'h2C, 32'h0, {2'h0, i[1:0], ac, 27'h0});
        end
        apb(1'b0, 8'h28, 32'h0, {17'h0, d[15:0]});
        // Translation-cache follow-up belongs to software outside this block.
        // Type bit is written while translation is off, now with extended support on.
        apb(1'b1, 8'h20, d | 32'h800, 33'h0);
        apb(1'b0, 8'h20, 32'h0, {1'b0, (d & 32'hFFFF_F000) | 32'h800});
        apb(1'b1, 8'h30, 32'h5, 33'h0);
        apb(1'b0, 8'h38, 32'h0, {1'b0, (d & 32'hFFFF_F000) | 32'h800});
        apb(1'b0, 8'h34, 32'h0, 33'h1);
        final_report();
    end
    initial begin
        #500000 miscompares++;
        final_report();
    end
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
endmodule
`default_nettype wire
